// >>> hdl/setl_consts.vh
// constants shared by the switch event and thermal logic
// assumes inclusion by bare name from every design file of this block
`ifndef SETL_CONSTS_VH
`define SETL_CONSTS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SETL_NUM_IN        24
`define SETL_NUM_COM       12
`define SETL_WC_W          3

// ----------------------------------------------------------------
// event status layout
// ----------------------------------------------------------------
`define SETL_IST_W         3
`define SETL_IST_SSC       0
`define SETL_IST_OH        1
`define SETL_IST_COM       2
`define SETL_IST_RST       3'h0

// ----------------------------------------------------------------
// debounce selection codes
// ----------------------------------------------------------------
`define SETL_DBN_ANY       2'h0
`define SETL_DBN_TWO       2'h1
`define SETL_DBN_THREE     2'h2
`define SETL_DBN_FOUR      2'h3
`define SETL_DBN_RST       2'h0

// ----------------------------------------------------------------
// wetting current codes
// ----------------------------------------------------------------
`define SETL_WC_0MA        3'h0
`define SETL_WC_1MA        3'h1
`define SETL_WC_2MA        3'h2
`define SETL_WC_5MA        3'h3
`define SETL_WC_10MA       3'h4
`define SETL_WC_15MA       3'h5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SETL_CNT_RST       2'h0
`define SETL_IN_RST        24'h000000
`define SETL_COM_RST       12'h000
`define SETL_WCV_RST       72'h000000000000000000

`endif

// >>> hdl/setl_chan_filter.v
// one switch input: reference status, edge qualification and debounce
// assumes sample_valid is a one-cycle pulse on core_clk per detection cycle
`timescale 1ns/10ps
`include "setl_consts.vh"

module setl_chan_filter (
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       scan_run,
  input  wire       sample_valid,
  input  wire       sample_above,
  input  wire [1:0] debounce_select,
  input  wire       rise_en,
  input  wire       fall_en,
  output reg        change_reg
);

  reg       ref_valid_reg;
  reg       ref_state_reg;
  reg [1:0] cnt_reg;

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_valid_reg <= 1'b0;
      ref_state_reg <= 1'b0;
      cnt_reg       <= `SETL_CNT_RST;
      change_reg    <= 1'b0;                                    // [RL6]
    end else begin
      change_reg <= 1'b0;
      if (!scan_run) begin
        cnt_reg       <= `SETL_CNT_RST;                         // [RL11]
        ref_valid_reg <= 1'b0;
      end else if (sample_valid) begin
        if (!ref_valid_reg) begin
          ref_state_reg <= sample_above;                        // [RL9]
          ref_valid_reg <= 1'b1;
          cnt_reg       <= `SETL_CNT_RST;
        end else if (sample_above != ref_state_reg) begin       // [RL26]
          // code n needs n+1 differing samples, crossing sample included
          if (cnt_reg == debounce_select) begin                 // [RL7] [RL8] [RL10] [RL12]
            ref_state_reg <= sample_above;
            cnt_reg       <= `SETL_CNT_RST;
            change_reg    <= (sample_above & rise_en) |         // [RL3] [RL5]
                             (~sample_above & fall_en);         // [RL4]
          end else begin
            cnt_reg <= cnt_reg + 2'h1;
          end
        end else begin
          // status fell back before being stable: start over
          cnt_reg <= `SETL_CNT_RST;
        end
      end
    end
  end

endmodule // setl_chan_filter

// >>> hdl/setl_wet_derate.v
// combinational wetting current derating for all inputs
// assumes the caller registers the result before it leaves the block
`timescale 1ns/10ps
`include "setl_consts.vh"

module setl_wet_derate (
  input  wire [71:0] wet_code_cfg,
  input  wire [23:0] input_is_sink,
  input  wire        overheat_live,
  input  wire        source_derate_disable,
  input  wire        sink_derate_disable,
  output wire [71:0] wet_code_eff
);

  function [2:0] derate_code;
    input [2:0] code;
    begin
      if (code == `SETL_WC_10MA || code == `SETL_WC_15MA)
        derate_code = `SETL_WC_2MA;                             // [RL16]
      else
        derate_code = code;
    end
  endfunction

  // ----------------------------------------------------------------
  // per input selection
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SETL_NUM_IN; g = g + 1) begin : g_in
      wire dis = input_is_sink[g] ? sink_derate_disable : source_derate_disable;
      wire [2:0] cfg = wet_code_cfg[g*3 +: 3];
      // derate only while warning is live and not disabled for this polarity
      assign wet_code_eff[g*3 +: 3] = (overheat_live && !dis) ? derate_code(cfg) : cfg; // [RL17] [RL20]
    end
  endgenerate

endmodule // setl_wet_derate

// >>> hdl/setl_event_logic.v
// switch event, interrupt status and overheat logic of the switch monitor
// assumes samples, enables and read strobe come from core_clk logic;
// cs_n, sclk and the sensor warning level are pins and are synchronised here
//
// Functional notes
// RL1: separate event enable per input, both modes
// RL2: shared threshold events have their own enable
// RL3: rising: now above, previously below threshold
// RL4: falling: now below, previously above threshold
// RL5: both edges: either crossing raises an event
// RL6: all input event enables off after reset
// RL7: debounce: any crossing, or 2/3/4 stable cycles
// RL8: code 11 needs four stable detection cycles
// RL9: reference status stored after first detection cycle
// RL10: debounce applies to comparator and ADC inputs
// RL11: debounce counter cleared when scan run drops
// RL12: reset debounce default is every crossing
// RL13: shared threshold events bypass debounce
// RL14: warning entry: alert low, flags, thermal bit
// RL15: live overheat status follows warning, not flags
// RL16: 10/15 mA derate to 2 mA unless disabled
// RL17: derated setting held while warning stays live
// RL18: cs rise after status read releases, clears
// RL19: no repeat warning interrupt while warning persists
// RL20: derate disable still gives interrupt and status
// RL21: warning exit: alert, flag, status clear, restore
// RL22: events kept until read; static alert only
// RL23: static alert held low until read ends
// RL24: status captured at first sclk rise, cleared after read
// RL25: sensor gives warning level, hysteresis resolved there
// RL26: previous result kept per input for comparison
`timescale 1ns/10ps
`include "setl_consts.vh"

module setl_event_logic (
  input  wire        core_clk,
  input  wire        rst_b,
  // scan and samples
  input  wire        scan_run,
  input  wire        sample_valid,
  input  wire [23:0] sample_above,
  input  wire [11:0] common_above,
  input  wire [23:0] input_is_adc,
  input  wire [23:0] input_is_sink,
  // configuration
  input  wire [1:0]  debounce_select,
  input  wire [23:0] comparator_event_enable_a,
  input  wire [23:0] comparator_event_enable_b,
  input  wire [23:0] adc_event_enable_1,
  input  wire [23:0] adc_event_enable_4,
  input  wire [1:0]  shared_threshold_enable,
  input  wire        source_derate_disable,
  input  wire        sink_derate_disable,
  input  wire [71:0] wet_code_cfg,
  // serial port
  input  wire        cs_n_pin,
  input  wire        sclk_pin,
  input  wire        status_read_cmd,
  // thermal sensor
  input  wire        overheat_warn_pin,
  // outputs
  output reg  [2:0]  int_stat_reg,
  output reg  [23:0] input_change_reg,
  output reg  [2:0]  int_stat_snap_reg,
  output reg  [23:0] input_change_snap_reg,
  output reg         alert_out_reg,
  output reg         alert_oe_reg,
  output reg         overheat_live_status,
  output reg         thermal_flag_reg,
  output reg  [71:0] wet_code_reg
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg cs_meta_reg;
  reg cs_sync_reg;
  reg cs_prev_reg;
  reg sclk_meta_reg;
  reg sclk_sync_reg;
  reg sclk_prev_reg;
  reg warn_meta_reg;
  reg warn_sync_reg;
  reg warn_prev_reg;

  // reset to idle levels so no false edge follows reset
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n_pin;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= sclk_pin;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      warn_meta_reg <= 1'b0;
      warn_sync_reg <= 1'b0;
      warn_prev_reg <= 1'b0;
    end else begin
      warn_meta_reg <= overheat_warn_pin;
      warn_sync_reg <= warn_meta_reg;
      warn_prev_reg <= warn_sync_reg;
    end
  end

  function edge_up;
    input prev;
    input now;
    begin
      edge_up = now & ~prev;
    end
  endfunction

  function edge_down;
    input prev;
    input now;
    begin
      edge_down = prev & ~now;
    end
  endfunction

  wire cs_fall   = edge_down(cs_prev_reg, cs_sync_reg);
  wire cs_rise   = edge_up(cs_prev_reg, cs_sync_reg);
  wire sclk_rise = edge_up(sclk_prev_reg, sclk_sync_reg);
  // hysteresis lives in the sensor; only the level edges matter here
  wire warn_enter = edge_up(warn_prev_reg, warn_sync_reg);      // [RL25]
  wire warn_exit  = edge_down(warn_prev_reg, warn_sync_reg);    // [RL25]

  // ----------------------------------------------------------------
  // per input detectors
  // ----------------------------------------------------------------
  wire [23:0] chan_change;

  // the input's mode decides which enable pair applies
  function [23:0] pick_enable;
    input [23:0] is_adc;
    input [23:0] adc_en;
    input [23:0] comp_en;
    begin
      pick_enable = (is_adc & adc_en) | (~is_adc & comp_en);
    end
  endfunction

  wire [23:0] rise_sel = pick_enable(input_is_adc, adc_event_enable_1, comparator_event_enable_a); // [RL1]
  wire [23:0] fall_sel = pick_enable(input_is_adc, adc_event_enable_4, comparator_event_enable_b); // [RL1]

  genvar g;
  generate
    for (g = 0; g < `SETL_NUM_IN; g = g + 1) begin : g_chan
      setl_chan_filter u_filter (
        .core_clk        (core_clk),
        .rst_b           (rst_b),
        .scan_run        (scan_run),
        .sample_valid    (sample_valid),
        .sample_above    (sample_above[g]),
        .debounce_select (debounce_select),
        .rise_en         (rise_sel[g]),
        .fall_en         (fall_sel[g]),
        .change_reg      (chan_change[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared threshold, evaluated without debounce
  // ----------------------------------------------------------------
  reg [11:0] com_prev_reg;
  reg        com_valid_reg;
  reg        com_event_reg;

  wire [11:0] com_up   = common_above & ~com_prev_reg;
  wire [11:0] com_down = ~common_above & com_prev_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      com_prev_reg  <= `SETL_COM_RST;
      com_valid_reg <= 1'b0;
      com_event_reg <= 1'b0;
    end else begin
      com_event_reg <= 1'b0;
      if (!scan_run) begin
        com_valid_reg <= 1'b0;
      end else if (sample_valid) begin
        com_prev_reg  <= common_above;
        com_valid_reg <= 1'b1;
        // one sample is enough: no stability count here
        com_event_reg <= com_valid_reg &&                       // [RL13]
                         (((|com_up) && shared_threshold_enable[0]) ||   // [RL2]
                          ((|com_down) && shared_threshold_enable[1]));  // [RL2]
      end
    end
  end

  // ----------------------------------------------------------------
  // serial transaction tracking
  // ----------------------------------------------------------------
  reg capture_armed_reg;
  reg read_seen_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_armed_reg <= 1'b0;
    end else if (cs_fall) begin
      capture_armed_reg <= 1'b1;
    end else if (sclk_rise || cs_sync_reg) begin
      capture_armed_reg <= 1'b0;
    end
  end

  // a read only counts inside a frame
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      read_seen_reg <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      read_seen_reg <= 1'b0;
    end else if (status_read_cmd && !cs_sync_reg) begin
      read_seen_reg <= 1'b1;
    end
  end

  wire capture_now = capture_armed_reg & sclk_rise;
  wire clear_now   = cs_rise & read_seen_reg;                   // [RL18]

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_snap_reg <= `SETL_IST_RST;
    end else if (capture_now) begin
      int_stat_snap_reg <= int_stat_reg;                        // [RL24]
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      input_change_snap_reg <= `SETL_IN_RST;
    end else if (capture_now) begin
      input_change_snap_reg <= input_change_reg;                // [RL24]
    end
  end

  // ----------------------------------------------------------------
  // event status
  // ----------------------------------------------------------------
  wire       ssc_event = |chan_change;
  wire       oh_event  = warn_enter | warn_exit;                // [RL14] [RL19] [RL21]
  wire [2:0] ist_set   = {com_event_reg, oh_event, ssc_event};
  wire       any_event = |ist_set;

  reg [2:0]  int_stat_next;
  reg [23:0] input_change_next;

  always @* begin
    int_stat_next     = int_stat_reg;
    input_change_next = input_change_reg;
    // only what the host saw is cleared; a new event survives the clear
    if (clear_now) begin
      int_stat_next     = int_stat_next & ~int_stat_snap_reg;   // [RL24]
      input_change_next = input_change_next & ~input_change_snap_reg;
    end
    int_stat_next     = int_stat_next | ist_set;                // [RL22]
    input_change_next = input_change_next | chan_change;
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_reg <= `SETL_IST_RST;
    end else begin
      int_stat_reg <= int_stat_next;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      input_change_reg <= `SETL_IN_RST;
    end else begin
      input_change_reg <= input_change_next;
    end
  end

  // ----------------------------------------------------------------
  // alert pin, static scheme only
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_out_reg <= 1'b0;
      alert_oe_reg  <= 1'b0;
    end else begin
      alert_out_reg <= 1'b0;
      if (any_event)
        alert_oe_reg <= 1'b1;                                   // [RL14] [RL21] [RL23]
      else if (clear_now)
        alert_oe_reg <= 1'b0;                                   // [RL18] [RL23]
    end
  end

  // ----------------------------------------------------------------
  // thermal status and wetting current
  // ----------------------------------------------------------------
  wire [71:0] wet_code_eff;

  setl_wet_derate u_derate (
    .wet_code_cfg          (wet_code_cfg),
    .input_is_sink         (input_is_sink),
    .overheat_live         (warn_sync_reg),
    .source_derate_disable (source_derate_disable),
    .sink_derate_disable   (sink_derate_disable),
    .wet_code_eff          (wet_code_eff)
  );

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overheat_live_status <= 1'b0;
      thermal_flag_reg     <= 1'b0;
    end else begin
      overheat_live_status <= warn_sync_reg;                    // [RL15] [RL21]
      // thermal bit in every status word while warning or its flag is up
      thermal_flag_reg     <= warn_sync_reg | int_stat_next[`SETL_IST_OH]; // [RL14]
    end
  end

  // derated codes leave the block only through this register
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wet_code_reg <= `SETL_WCV_RST;
    end else begin
      wet_code_reg <= wet_code_eff;                             // [RL16] [RL17] [RL20] [RL21]
    end
  end

endmodule // setl_event_logic

// >>> verification/setl_event_checker.sv
// concurrent checks on the ports of setl_event_logic
// assumes one clock core_clk and reset rst_b, active low
`timescale 1ns/10ps
module setl_event_checker (
  input wire        core_clk,
  input wire        rst_b,
  input wire        scan_run,
  input wire        sample_valid,
  input wire [23:0] sample_above,
  input wire [23:0] comparator_event_enable_a,
  input wire [23:0] comparator_event_enable_b,
  input wire [23:0] adc_event_enable_1,
  input wire [23:0] adc_event_enable_4,
  input wire        source_derate_disable,
  input wire        sink_derate_disable,
  input wire [71:0] wet_code_cfg,
  input wire        cs_n_pin,
  input wire        overheat_warn_pin,
  input wire [2:0]  int_stat_reg,
  input wire [23:0] input_change_reg,
  input wire        alert_oe_reg,
  input wire        overheat_live_status,
  input wire        thermal_flag_reg,
  input wire [71:0] wet_code_reg
);
  // ------
  // helpers
  // ------
  reg  [71:0] cfg_q;
  reg         keep_q;
  wire        take   = sample_valid & scan_run;
  wire        fall0  = comparator_event_enable_b[0] | adc_event_enable_4[0];
  wire        rise1  = comparator_event_enable_a[1] | adc_event_enable_1[1];
  wire        above0 = sample_above[0];
  wire        above1 = sample_above[1];

  // wetting codes land one edge after the configuration is sampled
  always @(posedge core_clk) begin
    cfg_q  <= wet_code_cfg;
    keep_q <= source_derate_disable | sink_derate_disable;
  end

  function automatic [2:0] low_cur(input [2:0] c);
    low_cur = (c == 3'h4 || c == 3'h5) ? 3'h2 : c;
  endfunction

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_warn_on;
    $rose(overheat_warn_pin) ##1 overheat_warn_pin [*3];
  endsequence
  sequence s_warn_off;
    $fell(overheat_warn_pin) ##1 !overheat_warn_pin [*3];
  endsequence

  // ------
  // assertions
  // ------
  a_live_on_entry: assert property (s_warn_on |-> overheat_live_status)
    else $error("live status missed a warning");
  a_live_off_exit: assert property (s_warn_off |-> !overheat_live_status)
    else $error("live status stuck after warning end");
  a_entry_flags: assert property ($rose(overheat_live_status) |-> int_stat_reg[1] && alert_oe_reg && thermal_flag_reg)
    else $error("warning entry did not flag");
  a_exit_flags: assert property ($fell(overheat_live_status) |-> int_stat_reg[1] && alert_oe_reg)
    else $error("warning exit did not flag");
  a_derate_live: assert property (overheat_live_status && !keep_q |->
    wet_code_reg[2:0] == low_cur(cfg_q[2:0]) && wet_code_reg[5:3] == low_cur(cfg_q[5:3]))
    else $error("wetting code not derated");
  a_restore_codes: assert property ($past(rst_b) && !overheat_live_status |-> wet_code_reg == cfg_q)
    else $error("wetting codes not restored");
  a_release_cs: assert property ($fell(alert_oe_reg) |-> cs_n_pin && $past(cs_n_pin))
    else $error("alert released inside a frame");
  a_stat_sticky: assert property ($fell(int_stat_reg[0]) |-> cs_n_pin)
    else $error("change status lost before frame end");
  a_rise_cause: assert property ($rose(input_change_reg[0]) && !$past(fall0, 2) |->
    ($past(take, 2) && $past(above0, 2)) || ($past(take, 3) && $past(above0, 3)))
    else $error("rising event without rising sample");
  a_fall_cause: assert property ($rose(input_change_reg[1]) && !$past(rise1, 2) |->
    ($past(take, 2) && !$past(above1, 2)) || ($past(take, 3) && !$past(above1, 3)))
    else $error("falling event without falling sample");
  a_common_cause: assert property ($rose(int_stat_reg[2]) |-> $past(take, 2) || $past(take, 3))
    else $error("shared threshold event without sample");
endmodule // setl_event_checker

bind setl_event_logic setl_event_checker u_chk (.*);

// >>> verification/setl_host_model.sv
// host side of the serial port: chip select, serial clock, read strobe
// assumes alert is open drain with a pull-up on the host side
`timescale 1ns/10ps
module setl_host_model (
  input  wire  core_clk,
  input  wire  alert_oe,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic status_read_cmd
);
  // pulled up whenever the device lets go
  wire alert_n = alert_oe ? 1'b0 : 1'b1;

  initial begin
    cs_n_pin        = 1'b1;
    sclk_pin        = 1'b0;
    status_read_cmd = 1'b0;
  end

  // ------
  // one frame; sclk stands low outside frames
  // ------
  task transact(input rd);
    @(posedge core_clk);
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    sclk_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    sclk_pin        <= 1'b0;
    status_read_cmd <= rd;
    @(posedge core_clk);
    status_read_cmd <= 1'b0;
    repeat (4) @(posedge core_clk);
    cs_n_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
endmodule // setl_host_model

// >>> verification/tb_setl_event_logic.sv
// self-checking bench for setl_event_logic
// assumes the host model drives the serial pins and the checker is bound
`timescale 1ns/10ps
module tb_setl_event_logic;
  logic        core_clk, rst_b, scan_run, sample_valid, status_read_cmd, cs_n_pin, sclk_pin;
  logic        source_derate_disable, sink_derate_disable, overheat_warn_pin;
  logic [1:0]  debounce_select, shared_threshold_enable;
  logic [11:0] common_above;
  logic [23:0] sample_above, input_is_adc, input_is_sink, v;
  logic [23:0] comparator_event_enable_a, comparator_event_enable_b, adc_event_enable_1, adc_event_enable_4;
  logic [71:0] wet_code_cfg;
  wire  [2:0]  int_stat_reg, int_stat_snap_reg;
  wire  [23:0] input_change_reg, input_change_snap_reg;
  wire         alert_out_reg, alert_oe_reg, overheat_live_status, thermal_flag_reg;
  wire  [71:0] wet_code_reg;
  integer      mismatches = 0, check_count = 0, i, k;

  setl_event_logic dut (.*);
  setl_host_model host (.core_clk(core_clk), .alert_oe(alert_oe_reg), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
                        .status_read_cmd(status_read_cmd));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ------
  // shared tasks
  // ------
  task chk(input [71:0] seen, input [71:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task samp(input [23:0] s, input [11:0] c);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_above <= s;
    common_above <= c;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // expected wetting codes, worked out per input
  function [71:0] wexp(input live, input src, input snk);
    integer g;
    reg [2:0] c;
    begin
      for (g = 0; g < 24; g = g + 1) begin
        c = wet_code_cfg[3*g +: 3];
        if (live && !(input_is_sink[g] ? snk : src) && c >= 3'h4) c = 3'h2;
        wexp[3*g +: 3] = c;
      end
    end
  endfunction

  initial begin
    #200000;
    mismatches = mismatches + 1;
    wrap_up;
  end

  // ------
  // main sequence
  // ------
  initial begin
    rst_b = 1'b0; scan_run = 1'b0; sample_valid = 1'b0; sample_above = 24'h0; common_above = 12'h0;
    input_is_adc = 24'h00000C; input_is_sink = 24'h000002; debounce_select = 2'h0; shared_threshold_enable = 2'h0;
    comparator_event_enable_a = 24'h0; comparator_event_enable_b = 24'h0;
    adc_event_enable_1 = 24'h0; adc_event_enable_4 = 24'h0; wet_code_cfg = 72'h0;
    source_derate_disable = 1'b0; sink_derate_disable = 1'b0; overheat_warn_pin = 1'b0; v = 24'h0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    scan_run <= 1'b1;
    samp(24'h00000A, 12'h0);
    samp(24'h000015, 12'h0);
    chk(input_change_reg, 24'h0);
    chk(int_stat_reg, 3'h0);
    @(posedge core_clk);
    comparator_event_enable_a <= 24'h000011;
    comparator_event_enable_b <= 24'h000012;
    adc_event_enable_1 <= 24'h000004;
    adc_event_enable_4 <= 24'h000008;
    samp(24'h00000A, 12'h0);
    chk(input_change_reg, 24'h000010);
    host.transact(1'b1);
    samp(24'h000015, 12'h0);
    chk(input_change_reg, 24'h00001F);
    chk({int_stat_reg, host.alert_n}, 4'h2);
    host.transact(1'b0);
    chk({input_change_reg, host.alert_n}, 25'h3E);
    host.transact(1'b1);
    chk(input_change_snap_reg, 24'h00001F);
    chk(int_stat_snap_reg, 3'h1);
    chk({input_change_reg, int_stat_reg, host.alert_n}, 28'h1);
    for (i = 1; i < 4; i = i + 1) begin
      @(posedge core_clk);
      debounce_select <= i[1:0];
      v = (i == 2) ? 24'h000015 : 24'h00000A;
      for (k = 0; k < i; k = k + 1) samp(v, 12'h0);
      chk(input_change_reg, 24'h0);
      samp(v, 12'h0);
      chk(input_change_reg, (i == 2) ? 24'h00001F : 24'h000010);
      host.transact(1'b1);
    end
    // three stable samples, then a scan stop must forget them
    for (k = 0; k < 3; k = k + 1) samp(24'h000015, 12'h0);
    @(posedge core_clk);
    scan_run <= 1'b0;
    input_is_adc <= 24'h000003;
    @(posedge core_clk);
    scan_run <= 1'b1;
    samp(24'h00000A, 12'h0);
    for (k = 0; k < 3; k = k + 1) samp(24'h000015, 12'h0);
    chk(input_change_reg, 24'h0);
    samp(24'h000015, 12'h0);
    chk(input_change_reg, 24'h000010);
    host.transact(1'b1);
    @(posedge core_clk);
    shared_threshold_enable <= 2'h1;
    samp(24'h000015, 12'h001);
    chk(int_stat_reg, 3'h4);
    host.transact(1'b1);
    samp(24'h000015, 12'h000);
    chk(int_stat_reg, 3'h0);
    @(posedge core_clk);
    shared_threshold_enable <= 2'h2;
    samp(24'h000015, 12'h010);
    chk(int_stat_reg, 3'h0);
    samp(24'h000015, 12'h000);
    chk(int_stat_reg, 3'h4);
    host.transact(1'b1);
    @(posedge core_clk);
    wet_code_cfg <= 72'h8E5;
    overheat_warn_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk({int_stat_reg, overheat_live_status, thermal_flag_reg, host.alert_n, alert_out_reg}, 7'h2C);
    chk(wet_code_reg, wexp(1'b1, 1'b0, 1'b0));
    host.transact(1'b1);
    repeat (8) @(posedge core_clk);
    #1;
    chk({int_stat_reg, overheat_live_status, thermal_flag_reg, host.alert_n}, 6'h7);
    chk(wet_code_reg, wexp(1'b1, 1'b0, 1'b0));
    @(posedge core_clk);
    source_derate_disable <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(wet_code_reg, wexp(1'b1, 1'b1, 1'b0));
    chk(int_stat_reg, 3'h0);
    @(posedge core_clk);
    input_is_sink <= 24'h000001;
    repeat (3) @(posedge core_clk);
    #1;
    chk(wet_code_reg, wexp(1'b1, 1'b1, 1'b0));
    @(posedge core_clk);
    sink_derate_disable <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(wet_code_reg, wexp(1'b1, 1'b1, 1'b1));
    @(posedge core_clk);
    overheat_warn_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    chk({int_stat_reg, overheat_live_status, host.alert_n}, 5'h8);
    chk(wet_code_reg, wexp(1'b0, 1'b1, 1'b0));
    wrap_up;
  end
endmodule // tb_setl_event_logic
